// ==== rst_params.svh ====
// Constants for the system reset controller and its watchdog
// Notes on behaviour
// - Seven reset causes: power-on, low voltage, watchdog, opcode, debug, pin, clock loss.
// - Every cause except the debug-forced reset has its own read-only cause bit.
// - The reset pin resets the chip only while its pin enable bit is set.
// - Entering reset puts the clock generator into self-clocked mode.
// - Entering reset drives the reset pin low for 34 bus cycles, then releases it.
// - 38 cycles after release the pin is sampled; low marks the pin as cause.
// - During reset peripherals are disabled and pins are floating inputs, no pull-ups.
// - Reset forces stack pointer 0x00FF, sets interrupt mask, loads PC from vector.
// - An enabled watchdog reaching its overflow count causes a system reset.
// - Watchdog enable bit is set after any reset; clearing it disables the watchdog.
// - Any write to the cause register clears the watchdog, contents stay unchanged.
// - Clock select bit: 0 picks the 1 kHz source, 1 picks the bus clock.
// - On 1 kHz the watchdog overflows after 32 or 256 ticks by timeout bit.
// - On bus clock the watchdog overflows after 2^13 or 2^18 cycles.
// - Reset defaults pick the 1 kHz source and the long 256-tick timeout.
// - Both option registers are write-once; later writes ignored until next reset.
// - The first write to either option register also clears the watchdog.
// - On bus clock the watchdog holds during debug or stop and then resumes.
// - On 1 kHz the watchdog is zeroed in debug or stop and restarts from zero.
`ifndef RST_PARAMS_SVH
`define RST_PARAMS_SVH

`define ADDR_CAUSE 8'h00
`define ADDR_OPT1 8'h04
`define ADDR_OPT2 8'h08
`define ADDR_STATUS 8'h0C

`define OPT1_WD_EN_BIT 7
`define OPT1_WD_TO_BIT 6
`define OPT2_WD_CLK_BIT 7
`define OPT2_PIN_EN_BIT 1
`define OPT1_RESET 8'hC0
`define OPT2_RESET 8'h02
`define OPT1_MASK 8'hC0
`define OPT2_MASK 8'h82

`define CAUSE_POR_BIT 7
`define CAUSE_PIN_BIT 6
`define CAUSE_WDOG_BIT 5
`define CAUSE_ILOP_BIT 4
`define CAUSE_CLK_BIT 2
`define CAUSE_LVD_BIT 1
`define CAUSE_RESET 8'h80

`define PIN_DRIVE_CYCLES 6'd34
`define PIN_SAMPLE_CYCLES 6'd38
`define SP_RESET 16'h00FF

`define WD_SLOW_SHORT 32
`define WD_SLOW_LONG 256
`define WD_BUS_SHORT 8192
`define WD_BUS_LONG 262144

`endif

// ==== rst_pkg.sv ====
// Types shared by the reset controller files
package rst_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_DRIVE, ST_WAIT, ST_HOLD} rst_state_e;
  typedef logic [17:0] wd_count_t;
endpackage : rst_pkg

// ==== sync2.sv ====
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta_reg <= INIT;
      q_o <= INIT;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule : sync2

// ==== watchdog_counter.sv ====
// Watchdog counter with two clock sources and two timeouts
`timescale 1ns/1ps
`include "rst_params.svh"
module watchdog_counter import rst_pkg::*; #(
  parameter int BUS_SHORT = `WD_BUS_SHORT,
  parameter int BUS_LONG = `WD_BUS_LONG
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic sys_reset_i,
  input wire logic service_i,
  input wire logic enable_i,
  input wire logic bus_clk_sel_i,
  input wire logic long_sel_i,
  input wire logic tick_i,
  input wire logic halt_i,
  output logic timeout_o,
  output wd_count_t count_o
);
  wd_count_t count_reg;
  wd_count_t count_next;
  wd_count_t limit;
  wire logic advance;
  wire logic at_limit;

  assign advance = bus_clk_sel_i ? !halt_i : tick_i;
  assign limit = bus_clk_sel_i ? (long_sel_i ? wd_count_t'(BUS_LONG - 1) :
                 wd_count_t'(BUS_SHORT - 1)) :
                 (long_sel_i ? wd_count_t'(`WD_SLOW_LONG - 1) :
                 wd_count_t'(`WD_SLOW_SHORT - 1));
  assign at_limit = enable_i && advance && (count_reg >= limit);

  // Clear wins over counting so a service never loses to a tick
  always_comb begin
    count_next = count_reg;
    if (sys_reset_i || service_i || !enable_i) begin
      count_next = '0;
    end else if (!bus_clk_sel_i && halt_i) begin
      count_next = '0;
    end else if (at_limit) begin
      count_next = '0;
    end else if (advance) begin
      count_next = count_reg + 18'h00001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      count_reg <= '0;
      timeout_o <= 1'b0;
    end else begin
      count_reg <= count_next;
      timeout_o <= at_limit && !sys_reset_i && !service_i;
    end
  end

  assign count_o = count_reg;
endmodule : watchdog_counter

// ==== system_reset_watchdog.sv ====
// System reset controller with reset pin sequencing, cause record and watchdog
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "rst_params.svh"
module system_reset_watchdog import rst_pkg::*; #(
  parameter int BUS_SHORT = `WD_BUS_SHORT,
  parameter int BUS_LONG = `WD_BUS_LONG,
  parameter logic [15:0] RESET_VECTOR = 16'hFFFE
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Reset sources
  input wire logic low_voltage_detect_i,
  input wire logic clock_loss_i,
  input wire logic illegal_opcode_i,
  input wire logic debug_force_reset_i,
  input wire logic tick_1khz_i,
  input wire logic debug_mode_i,
  input wire logic stop_mode_i,
  // Reset pin, open drain
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe_o,
  // System side
  output logic system_reset_o,
  output logic self_clock_mode_o,
  output logic periph_disable_o,
  output logic io_float_o,
  output logic pullup_disable_o,
  output logic [15:0] stack_pointer_o,
  output logic imask_set_o,
  output logic pc_load_vector_o,
  output logic [15:0] pc_vector_o
);
  // Synchronised pin-level inputs
  wire logic lvd_s;
  wire logic clk_loss_s;
  wire logic pin_s;
  wire logic tick_s;
  wire logic tick_rise;
  logic tick_prev_reg;

  // Sequencer and registers
  rst_state_e state_reg;
  rst_state_e state_next;
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic [7:0] pending_reg;
  logic [7:0] pending_next;
  logic [7:0] cause_reg;
  logic [7:0] opt1_reg;
  logic [7:0] opt2_reg;
  logic opt1_lock_reg;
  logic opt2_lock_reg;

  // Watchdog wires
  wire logic wd_timeout;
  wd_count_t wd_count;
  wire logic wd_enable;
  wire logic wd_bus_clk;
  wire logic wd_long;
  wire logic wd_halt;

  // Bus decode wires
  wire logic setup_acc;
  wire logic wr_done;
  wire logic hit_cause;
  wire logic hit_opt1;
  wire logic hit_opt2;
  wire logic hit_status;
  wire logic mapped;
  wire logic wr_cause;
  wire logic wr_opt1;
  wire logic wr_opt2;
  wire logic wd_service;

  // Reset gathering and sequencer views
  wire logic in_reset;
  wire logic pin_enable;
  wire logic [7:0] new_causes;
  wire logic trigger;
  wire logic reset_next;
  wire logic drive_next;
  wire logic leave_reset;
  logic [31:0] rdata_mux;

  // Pins and other-domain levels pass two flops before use
  // Reset values match idle levels: pin high, the others low
  sync2 #(
    .WIDTH(4),
    .INIT(4'h4)
  ) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i({low_voltage_detect_i, reset_pin_i, clock_loss_i, tick_1khz_i}),
    .q_o({lvd_s, pin_s, clk_loss_s, tick_s})
  );

  // Rising edge of the synchronised 1 kHz clock makes one tick
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tick_prev_reg <= 1'b0;
    end else begin
      tick_prev_reg <= tick_s;
    end
  end

  // One-cycle tick on each rising edge of the slow clock
  assign tick_rise = tick_s && !tick_prev_reg;

  // Reset source gathering
  assign in_reset = (state_reg != ST_RUN);
  assign pin_enable = opt2_reg[`OPT2_PIN_EN_BIT];
  // All seven causes trigger reset; debug has no cause bit
  assign new_causes[`CAUSE_POR_BIT] = 1'b0;
  assign new_causes[`CAUSE_PIN_BIT] = pin_enable && !pin_s;
  assign new_causes[`CAUSE_WDOG_BIT] = wd_timeout;
  assign new_causes[`CAUSE_ILOP_BIT] = illegal_opcode_i;
  // Unused cause positions read zero
  assign new_causes[3] = 1'b0;
  assign new_causes[`CAUSE_CLK_BIT] = clk_loss_s;
  assign new_causes[`CAUSE_LVD_BIT] = lvd_s;
  assign new_causes[0] = 1'b0;
  // Debug force starts a sequence but leaves no cause bit
  assign trigger = (|new_causes) || debug_force_reset_i;

  // Next-state views shared by the output flops, so outputs land with the state
  assign reset_next = (state_next != ST_RUN);
  assign drive_next = (state_next == ST_DRIVE);
  assign leave_reset = in_reset && !reset_next;

  // Reset sequence: drive pin, release, wait, sample
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pending_next = pending_reg;
    unique case (state_reg)
      ST_RUN: begin
        // Causes arriving mid-sequence are not taken
        if (trigger) begin
          state_next = ST_DRIVE;
          cnt_next = '0;
          pending_next = new_causes;
        end
      end
      ST_DRIVE: begin
        if (cnt_reg == `PIN_DRIVE_CYCLES - 6'd1) begin
          state_next = ST_WAIT;
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + 6'd1;
        end
      end
      ST_WAIT: begin
        if (cnt_reg == `PIN_SAMPLE_CYCLES - 6'd1) begin
          state_next = pin_s ? ST_RUN : ST_HOLD;
          cnt_next = '0;
          // Pin bit set on a low sample even with the pin enable clear
          if (!pin_s) begin
            pending_next[`CAUSE_PIN_BIT] = 1'b1;
          end
        end else begin
          cnt_next = cnt_reg + 6'd1;
        end
      end
      ST_HOLD: begin
        // An external low pin keeps the chip in reset
        if (pin_s) begin
          state_next = ST_RUN;
        end
      end
    endcase
  end

  // Sequencer state; power-on starts a full pin sequence
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_reg <= ST_DRIVE;
      cnt_reg <= '0;
      pending_reg <= `CAUSE_RESET;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pending_reg <= pending_next;
    end
  end

  // Cause register shows the last completed reset only
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cause_reg <= `CAUSE_RESET;
    end else if (leave_reset) begin
      cause_reg <= pending_next;
    end
  end

  // APB decode; one wait state so read data comes from a flop
  assign setup_acc = psel_i && penable_i && !pready_o;
  assign wr_done = psel_i && penable_i && pready_o && pwrite_i;
  assign hit_cause = (paddr_i == `ADDR_CAUSE);
  assign hit_opt1 = (paddr_i == `ADDR_OPT1);
  assign hit_opt2 = (paddr_i == `ADDR_OPT2);
  assign hit_status = (paddr_i == `ADDR_STATUS);
  assign mapped = hit_cause || hit_opt1 || hit_opt2 || hit_status;
  assign wr_cause = wr_done && hit_cause;
  // Option writes during a sequence are dropped without an error
  assign wr_opt1 = wr_done && hit_opt1 && !opt1_lock_reg && !in_reset;
  assign wr_opt2 = wr_done && hit_opt2 && !opt2_lock_reg && !in_reset;
  // First option write clears it too
  assign wd_service = wr_cause || wr_opt1 || wr_opt2;

  // Read mux; status shows sequencer state, locks and the whole count in bits 31:14
  always_comb begin
    rdata_mux = 32'h00000000;
    if (hit_cause) begin
      rdata_mux[7:0] = cause_reg;
    end else if (hit_opt1) begin
      rdata_mux[7:0] = opt1_reg;
    end else if (hit_opt2) begin
      rdata_mux[7:0] = opt2_reg;
    end else if (hit_status) begin
      rdata_mux[1:0] = {opt2_lock_reg, opt1_lock_reg};
      rdata_mux[3:2] = state_reg;
      rdata_mux[31:14] = wd_count;
    end
  end

  // Bus answer registers
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else begin
      // Error and data ride with ready for its single cycle
      pready_o <= setup_acc;
      pslverr_o <= setup_acc && !mapped;
      prdata_o <= setup_acc && !pwrite_i ? rdata_mux : 32'h00000000;
    end
  end

  // Option one returns to enabled, long timeout on every reset
  always_ff @(posedge clk_i) begin
    if (!rstn_i || in_reset) begin
      opt1_reg <= `OPT1_RESET;
      opt1_lock_reg <= 1'b0;
    end else if (wr_opt1) begin
      // First write locks until next reset
      opt1_reg <= pwdata_i[7:0] & `OPT1_MASK;
      opt1_lock_reg <= 1'b1;
    end
  end

  // Option two returns to the 1 kHz source, pin enabled
  always_ff @(posedge clk_i) begin
    if (!rstn_i || in_reset) begin
      opt2_reg <= `OPT2_RESET;
      opt2_lock_reg <= 1'b0;
    end else if (wr_opt2) begin
      // Each register locks on its own
      opt2_reg <= pwdata_i[7:0] & `OPT2_MASK;
      opt2_lock_reg <= 1'b1;
    end
  end

  // Option fields that steer the watchdog
  assign wd_enable = opt1_reg[`OPT1_WD_EN_BIT];
  assign wd_bus_clk = opt2_reg[`OPT2_WD_CLK_BIT];
  assign wd_long = opt1_reg[`OPT1_WD_TO_BIT];
  // Debug and stop both halt the counter
  assign wd_halt = debug_mode_i || stop_mode_i;

  // Watchdog counter; a service write beats an overflow in the same cycle
  watchdog_counter #(
    .BUS_SHORT(BUS_SHORT),
    .BUS_LONG(BUS_LONG)
  ) u_wdog (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .sys_reset_i(in_reset),
    .service_i(wd_service),
    .enable_i(wd_enable),
    .bus_clk_sel_i(wd_bus_clk),
    .long_sel_i(wd_long),
    .tick_i(tick_rise),
    .halt_i(wd_halt),
    .timeout_o(wd_timeout),
    .count_o(wd_count)
  );

  // Open drain pin: drive low, else release to the pull-up
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      reset_pin_o <= 1'b0;
      reset_pin_oe_o <= 1'b1;
    end else begin
      reset_pin_o <= 1'b0;
      reset_pin_oe_o <= drive_next;
    end
  end

  // System side follows the sequencer's next state
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      system_reset_o <= 1'b1;
      self_clock_mode_o <= 1'b1;
      periph_disable_o <= 1'b1;
      io_float_o <= 1'b1;
      pullup_disable_o <= 1'b1;
    end else begin
      system_reset_o <= reset_next;
      self_clock_mode_o <= reset_next;
      periph_disable_o <= reset_next;
      io_float_o <= reset_next;
      pullup_disable_o <= reset_next;
    end
  end

  // CPU start state; constants are flopped so outputs stay registered
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      stack_pointer_o <= `SP_RESET;
      imask_set_o <= 1'b1;
      pc_load_vector_o <= 1'b1;
      pc_vector_o <= RESET_VECTOR;
    end else begin
      stack_pointer_o <= `SP_RESET;
      imask_set_o <= reset_next;
      pc_load_vector_o <= reset_next;
      pc_vector_o <= RESET_VECTOR;
    end
  end
endmodule : system_reset_watchdog

// ==== system_reset_watchdog_props.sv ====
// Concurrent checks on the reset controller ports
`timescale 1ns/1ps
module system_reset_watchdog_props (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic illegal_opcode_i,
  input wire logic debug_force_reset_i,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe_o,
  input wire logic system_reset_o,
  input wire logic self_clock_mode_o,
  input wire logic periph_disable_o,
  input wire logic io_float_o,
  input wire logic pullup_disable_o,
  input wire logic [15:0] stack_pointer_o,
  input wire logic imask_set_o,
  input wire logic pc_load_vector_o
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // Bus answers after exactly one wait state and only for one cycle
  a_apb_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("Bus ready late");
  a_ready_single: assert property (pready_o |=> !pready_o)
    else $error("Bus ready held too long");
  a_err_unmapped: assert property (psel_i && penable_i && !pready_o && paddr_i > 8'h0C
    |=> pslverr_o && pready_o)
    else $error("Unmapped access not flagged");
  a_pin_drive_len: assert property (
    $rose(reset_pin_oe_o) |-> (reset_pin_oe_o throughout ##33 1) ##1 !reset_pin_oe_o)
    else $error("Reset pin drive length wrong");
  a_pin_only_low: assert property (
    reset_pin_oe_o |-> !reset_pin_o)
    else $error("Reset pin driven high");
  a_release_wait: assert property (
    $fell(reset_pin_oe_o) |-> (system_reset_o && !reset_pin_oe_o) throughout ##37 1)
    else $error("Reset left before pin sample");
  a_exit_after_wait: assert property (
    $fell(system_reset_o) |-> !$past(reset_pin_oe_o, 38))
    else $error("Reset exit too soon after release");
  a_cause_enters: assert property (
    (illegal_opcode_i || debug_force_reset_i) && !system_reset_o
    |=> system_reset_o && reset_pin_oe_o)
    else $error("Reset cause not taken");
  a_reset_outputs: assert property (
    {self_clock_mode_o, periph_disable_o, io_float_o, pullup_disable_o, imask_set_o,
    pc_load_vector_o} == {6{system_reset_o}} && stack_pointer_o == 16'h00FF)
    else $error("Reset side outputs wrong");

  // Main scenarios reached
  c_reset_exit: cover property ($fell(system_reset_o));
  c_bus_error: cover property (pslverr_o);
  c_pin_drive: cover property ($rose(reset_pin_oe_o));
endmodule : system_reset_watchdog_props

bind system_reset_watchdog system_reset_watchdog_props u_props (.*);

// ==== pin_partner.sv ====
// Reset pin with pull-up and a shortened stand-in for the 1 kHz source
`timescale 1ns/1ps
module pin_partner #(
  parameter int HALF = 2
) (
  input wire logic clk_i,
  input wire logic oe_i,
  input wire logic hold_low_i,
  output logic pin_o,
  output logic tick_o
);
  int cnt = 0;

  assign pin_o = !(oe_i || hold_low_i);

  // Slow source is sped up so the long timeouts fit the run
  initial tick_o = 1'b0;
  always @(posedge clk_i) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      tick_o <= !tick_o;
    end
  end
endmodule : pin_partner

// ==== tb_top.sv ====
// Self-checking bench for the reset controller and watchdog
`timescale 1ns/1ps
module tb_top;
  localparam int SHORT = 16, LONG = 64, MUL = 4;
  logic clk_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [3:0] src = 4'h0;
  logic debug_mode_i = 1'b0, stop_mode_i = 1'b0, hold_low = 1'b0, er;
  logic pready_o, pslverr_o, tick_1khz_i, reset_pin_i, reset_pin_oe_o, system_reset_o;
  logic [15:0] stack_pointer_o, pc_vector_o;
  int fail_count = 0, tests_run = 0, t, w, d, p, e, win;

  always #5 clk_i = ~clk_i;

  system_reset_watchdog #(.BUS_SHORT(SHORT), .BUS_LONG(LONG)) DUT (.clk_i, .rstn_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .low_voltage_detect_i(src[2]), .clock_loss_i(src[1]), .illegal_opcode_i(src[3]),
    .debug_force_reset_i(src[0]), .tick_1khz_i, .debug_mode_i, .stop_mode_i, .reset_pin_i,
    .reset_pin_o(), .reset_pin_oe_o, .system_reset_o, .self_clock_mode_o(),
    .periph_disable_o(), .io_float_o(), .pullup_disable_o(), .stack_pointer_o,
    .imask_set_o(), .pc_load_vector_o(), .pc_vector_o);

  pin_partner #(.HALF(MUL / 2)) partner (.clk_i, .oe_i(reset_pin_oe_o),
    .hold_low_i(hold_low), .pin_o(reset_pin_i), .tick_o(tick_1khz_i));

  task automatic end_of_test();
    $display("checks %0d failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Setup, access until ready, then release; one idle edge keeps drivers race-free
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    w = 0;
    do begin
      @(posedge clk_i);
      w++;
    end while (pready_o !== 1'b1 && w < 20);
    if (pready_o !== 1'b1) begin
      check("bus_ready", 32'h1, 32'h0);
      end_of_test();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    check(name, {24'h0, exp}, rd);
  endtask : rdchk

  task automatic wait_sys(input logic lvl, input int lim);
    t = 0;
    while (system_reset_o !== lvl && t < lim) begin
      @(posedge clk_i);
      t++;
    end
    if (system_reset_o !== lvl) begin
      check("wait_limit", 32'h0, 32'h1);
      end_of_test();
    end
  endtask : wait_sys

  function automatic logic [7:0] cause_exp(int i);
    return i == 0 ? 8'h10 : i == 1 ? 8'h02 : i == 2 ? 8'h04 : 8'h00;
  endfunction : cause_exp

  // Edges from option write to reset; slow source restarts from zero after a halt
  function automatic int wd_exp(int i, int dd, int pp);
    if (i[1]) return (i[0] ? LONG : SHORT) + dd;
    return (i[0] ? 256 : 32) * MUL + pp + 1 + dd;
  endfunction : wd_exp

  // Main sequence
  initial begin
    void'($urandom(51));
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    wait_sys(1'b0, 400);
    rdchk(8'h00, 8'h80, "cause_por");
    rdchk(8'h04, 8'hC0, "opt1_reset");
    rdchk(8'h08, 8'h02, "opt2_reset");
    check("stack_ptr", 32'h00FF, {16'h0, stack_pointer_o});
    check("pc_vector", 32'hFFFE, {16'h0, pc_vector_o});
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped_err", 32'h1, {31'h0, er});
    apb(1'b1, 8'h04, 32'hC0);
    apb(1'b1, 8'h04, 32'h00);
    rdchk(8'h04, 8'hC0, "opt1_locked");
    apb(1'b0, 8'h0C, 32'h0);
    check("status_locks", 32'h1, rd & 32'h0000000F);
    // Services with random data spread over more than one long timeout
    // Services come only from this main flow, never from a periodic process
    repeat (12) begin
      apb(1'b1, 8'h00, $urandom);
      repeat (100 + $urandom % 100) @(posedge clk_i);
    end
    check("no_wd_reset", 32'h0, {31'h0, system_reset_o});
    rdchk(8'h00, 8'h80, "cause_kept");
    apb(1'b1, 8'h08, 32'h00);
    apb(1'b1, 8'h08, 32'h02);
    rdchk(8'h08, 8'h00, "opt2_locked");
    hold_low <= 1'b1;
    repeat (30) @(posedge clk_i);
    check("pin_ignored", 32'h0, {31'h0, system_reset_o});
    hold_low <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      src <= 4'b1000 >> i;
      repeat (3) @(posedge clk_i);
      src <= 4'b0000;
      wait_sys(1'b1, 20);
      wait_sys(1'b0, 400);
      rdchk(8'h00, cause_exp(i), "cause_src");
    end
    hold_low <= 1'b1;
    repeat (200) @(posedge clk_i);
    check("pin_held", 32'h1, {31'h0, system_reset_o});
    hold_low <= 1'b0;
    wait_sys(1'b0, 400);
    rdchk(8'h00, 8'h40, "cause_pin");
    // Every source and timeout, with a random halt in debug or stop
    for (int i = 0; i < 4; i++) begin
      d = 5 + $urandom % 16;
      p = i[1] ? 12 : 40;
      win = i[1] ? 0 : MUL;
      apb(1'b1, 8'h08, {24'h0, i[1], 7'h02});
      apb(1'b1, 8'h04, {24'h0, 1'b1, i[0], 6'h00});
      repeat (p) @(posedge clk_i);
      {stop_mode_i, debug_mode_i} <= ($urandom % 2) ? 2'b10 : 2'b01;
      repeat (d) @(posedge clk_i);
      {stop_mode_i, debug_mode_i} <= 2'b00;
      wait_sys(1'b1, 2000);
      e = wd_exp(i, d, p);
      t = t + p + 1 + d;
      check("wd_time", 32'h1, {31'h0, t >= e - win && t <= e + 4 + 2 * win});
      wait_sys(1'b0, 400);
      rdchk(8'h00, 8'h20, "cause_wd");
      rdchk(8'h04, 8'hC0, "opt1_back");
    end
    end_of_test();
  end
endmodule : tb_top
